// >>> include/lsb_pkg.sv
// package: operation codes, sizes and field layout for the logic/shift/bit alu
package lsb_pkg;
    // =========================================================
    // operand sizes
    typedef enum logic [1:0] {
        LSB_SZ_BYTE,
        LSB_SZ_WORD,
        LSB_SZ_LONG
    } lsb_size_t;

    // =========================================================
    // operation codes
    typedef enum logic [4:0] {
        LSB_OP_AND,
        LSB_OP_OR,
        LSB_OP_XOR,
        LSB_OP_NOT,
        LSB_OP_ARITH_SHIFT_LEFT,
        LSB_OP_ARITH_SHIFT_RIGHT,
        LSB_OP_LOGIC_SHIFT_LEFT,
        LSB_OP_LOGIC_SHIFT_RIGHT,
        LSB_OP_ROTATE_LEFT,
        LSB_OP_ROTATE_RIGHT,
        LSB_OP_ROTATE_CARRY_LEFT,
        LSB_OP_ROTATE_CARRY_RIGHT,
        LSB_OP_BIT_SET,
        LSB_OP_BIT_CLEAR,
        LSB_OP_BIT_INVERT,
        LSB_OP_BIT_TEST,
        LSB_OP_CARRY_AND_BIT,
        LSB_OP_CARRY_AND_INV_BIT,
        LSB_OP_CARRY_OR_BIT,
        LSB_OP_CARRY_OR_INV_BIT,
        LSB_OP_CARRY_XOR_BIT,
        LSB_OP_CARRY_XOR_INV_BIT,
        LSB_OP_BIT_LOAD_CARRY,
        LSB_OP_INV_BIT_LOAD_CARRY,
        LSB_OP_CARRY_STORE_BIT,
        LSB_OP_INV_CARRY_STORE_BIT
    } lsb_op_t;

    // =========================================================
    // widths and field positions
    localparam int LSB_DATA_W = 32;
    localparam int LSB_IDX_W = 3;
    localparam int LSB_REG_SEL_W = 3;
    localparam int LSB_BYTE_MSB = 7;
    localparam int LSB_WORD_MSB = 15;
    localparam int LSB_LONG_MSB = 31;
    localparam logic [31:0] LSB_DATA_RST = 32'h0000_0000;
    localparam logic LSB_FLAG_RST = 1'b0;
    localparam int LSB_LATENCY = 1;
endpackage : lsb_pkg

// >>> include/lsb_bit_if.sv
// interface: byte operand and bit-op request between top and bit unit
`timescale 1ns/1ps
interface lsb_bit_if;
    import lsb_pkg::*;
    logic [7:0] byte_val;
    logic [2:0] bit_idx;
    lsb_op_t op;
    logic carry_val;
    logic [7:0] byte_res;
    logic carry_res;
    logic zero_res;
    logic carry_wr;
    logic zero_wr;
    logic byte_wr;
    logic legal;
    modport top (output byte_val, bit_idx, op, carry_val,
                 input byte_res, carry_res, zero_res, carry_wr,
                 zero_wr, byte_wr, legal);
    modport unit (input byte_val, bit_idx, op, carry_val,
                  output byte_res, carry_res, zero_res, carry_wr,
                  zero_wr, byte_wr, legal);
endinterface : lsb_bit_if

// >>> src/lsb_bit_unit.sv
// combinational single-bit manipulation unit
`timescale 1ns/1ps
module lsb_bit_unit
    import lsb_pkg::*;
(
    lsb_bit_if.unit bus // byte operand, index and op in, results out
);
    logic sel_bit;

    // =========================================================
    // bit operations on one byte
    always_comb begin
        sel_bit = bus.byte_val[bus.bit_idx];
        bus.byte_res = bus.byte_val;
        bus.carry_res = bus.carry_val;
        bus.zero_res = 1'b0;
        bus.carry_wr = 1'b0;
        bus.zero_wr = 1'b0;
        bus.byte_wr = 1'b0;
        bus.legal = 1'b1;
        case (bus.op)
            LSB_OP_BIT_SET: begin
                bus.byte_res[bus.bit_idx] = 1'b1;
                bus.byte_wr = 1'b1;
            end
            LSB_OP_BIT_CLEAR: begin
                bus.byte_res[bus.bit_idx] = 1'b0;
                bus.byte_wr = 1'b1;
            end
            LSB_OP_BIT_INVERT: begin
                bus.byte_res[bus.bit_idx] = ~sel_bit;
                bus.byte_wr = 1'b1;
            end
            LSB_OP_BIT_TEST: begin
                bus.zero_res = ~sel_bit;
                bus.zero_wr = 1'b1;
            end
            LSB_OP_CARRY_AND_BIT: begin
                bus.carry_res = bus.carry_val & sel_bit;
                bus.carry_wr = 1'b1;
            end
            LSB_OP_CARRY_AND_INV_BIT: begin
                bus.carry_res = bus.carry_val & ~sel_bit;
                bus.carry_wr = 1'b1;
            end
            LSB_OP_CARRY_OR_BIT: begin
                bus.carry_res = bus.carry_val | sel_bit;
                bus.carry_wr = 1'b1;
            end
            LSB_OP_CARRY_OR_INV_BIT: begin
                bus.carry_res = bus.carry_val | ~sel_bit;
                bus.carry_wr = 1'b1;
            end
            LSB_OP_CARRY_XOR_BIT: begin
                bus.carry_res = bus.carry_val ^ sel_bit;
                bus.carry_wr = 1'b1;
            end
            LSB_OP_CARRY_XOR_INV_BIT: begin
                bus.carry_res = bus.carry_val ^ ~sel_bit;
                bus.carry_wr = 1'b1;
            end
            LSB_OP_BIT_LOAD_CARRY: begin
                bus.carry_res = sel_bit;
                bus.carry_wr = 1'b1;
            end
            LSB_OP_INV_BIT_LOAD_CARRY: begin
                bus.carry_res = ~sel_bit;
                bus.carry_wr = 1'b1;
            end
            LSB_OP_CARRY_STORE_BIT: begin
                bus.byte_res[bus.bit_idx] = bus.carry_val;
                bus.byte_wr = 1'b1;
            end
            LSB_OP_INV_CARRY_STORE_BIT: begin
                bus.byte_res[bus.bit_idx] = ~bus.carry_val;
                bus.byte_wr = 1'b1;
            end
            default: begin
                bus.legal = 1'b0;
            end
        endcase
    end
endmodule : lsb_bit_unit

// >>> src/lsb_alu.sv
// logic, shift/rotate and bit-manipulation execution datapath
`timescale 1ns/1ps
module lsb_alu
    import lsb_pkg::*;
(
    input wire logic clock_in, // 200 MHz core clock
    input wire logic rst_b_in, // synchronous reset, active low
    input wire logic start_in, // one-cycle request strobe
    input wire lsb_op_t op_in, // operation code
    input wire lsb_size_t size_in, // operand size
    input wire logic [31:0] dst_in, // destination register contents
    input wire logic [31:0] src_in, // source register contents
    input wire logic [31:0] immediate_value_in, // immediate operand
    input wire logic use_imm_in, // 1: immediate, 0: source register
    input wire logic [2:0] bit_idx_imm_in, // 3-bit immediate bit index
    input wire logic bit_idx_from_reg_in, // index from source reg bits
    input wire logic [7:0] mem_byte_in, // memory byte for bit ops
    input wire logic use_mem_in, // bit op works on memory byte
    input wire logic byte_high_in, // byte op on high half (bits 15:8)
    input wire logic word_upper_in, // word op on upper half (31:16)
    input wire logic carry_in, // current carry flag
    output logic done_out, // one-cycle result valid
    output logic [31:0] result_out, // merged 32-bit register value
    output logic reg_wr_out, // write result_out to destination
    output logic [7:0] mem_byte_out, // modified memory byte
    output logic mem_wr_out, // write mem_byte_out back
    output logic carry_out, // new carry flag value
    output logic carry_wr_out, // carry flag update strobe
    output logic zero_out, // new zero flag value
    output logic zero_wr_out, // zero flag update strobe
    output logic illegal_out // request refused (bad op/index form)
);
    // =========================================================
    // state
    typedef struct packed {
        logic done;
        logic [31:0] result;
        logic reg_wr;
        logic [7:0] mem_byte;
        logic mem_wr;
        logic carry;
        logic carry_wr;
        logic zero;
        logic zero_wr;
        logic illegal;
    } lsb_state_t;

    lsb_state_t st_ff;
    lsb_state_t nxt_st;

    lsb_bit_if bit_bus();

    logic [31:0] opnd;
    logic [31:0] src_val;
    logic [31:0] logic_res;
    logic [31:0] shift_res;
    logic shift_carry;
    logic is_logic;
    logic is_shift;
    logic is_bit;
    logic imm_only;
    logic [7:0] bit_byte;
    logic [31:0] merged;
    logic msb;
    logic lsb_bit;
    logic [31:0] sz_mask;

    // =========================================================
    // operand extraction by size, right-aligned
    always_comb begin
        opnd = LSB_DATA_RST;
        sz_mask = LSB_DATA_RST;
        case (size_in)
            LSB_SZ_BYTE: begin
                opnd[7:0] = byte_high_in ? dst_in[15:8] : dst_in[7:0];
                sz_mask = 32'h0000_00FF;
            end
            LSB_SZ_WORD: begin
                opnd[15:0] = word_upper_in ? dst_in[31:16] : dst_in[15:0];
                sz_mask = 32'h0000_FFFF;
            end
            LSB_SZ_LONG: begin
                opnd = dst_in;
                sz_mask = 32'hFFFF_FFFF;
            end
            default: begin
                opnd = dst_in;
                sz_mask = 32'hFFFF_FFFF;
            end
        endcase
        // source is taken right-aligned; the decoder places halves
        src_val = (use_imm_in ? immediate_value_in : src_in) & sz_mask;
    end

    // =========================================================
    // logic operations, trimmed to operand size
    always_comb begin
        is_logic = 1'b1;
        case (op_in)
            LSB_OP_AND: logic_res = opnd & src_val;
            LSB_OP_OR: logic_res = opnd | src_val;
            LSB_OP_XOR: logic_res = opnd ^ src_val;
            LSB_OP_NOT: logic_res = ~opnd & sz_mask;
            default: begin
                logic_res = opnd;
                is_logic = 1'b0;
            end
        endcase
    end

    // =========================================================
    // single-bit shifts and rotates; msb position follows size
    always_comb begin
        case (size_in)
            LSB_SZ_BYTE: msb = opnd[LSB_BYTE_MSB];
            LSB_SZ_WORD: msb = opnd[LSB_WORD_MSB];
            default: msb = opnd[LSB_LONG_MSB];
        endcase
        lsb_bit = opnd[0];
        is_shift = 1'b1;
        shift_res = opnd;
        shift_carry = carry_in;
        case (op_in)
            LSB_OP_ARITH_SHIFT_LEFT, LSB_OP_LOGIC_SHIFT_LEFT: begin
                shift_res = (opnd << 1) & sz_mask;
                shift_carry = msb;
            end
            LSB_OP_ARITH_SHIFT_RIGHT: begin
                shift_res = (opnd >> 1) | (msb ? ((sz_mask >> 1) ^ sz_mask)
                                               : LSB_DATA_RST);
                shift_carry = lsb_bit;
            end
            LSB_OP_LOGIC_SHIFT_RIGHT: begin
                shift_res = opnd >> 1;
                shift_carry = lsb_bit;
            end
            LSB_OP_ROTATE_LEFT: begin
                shift_res = ((opnd << 1) & sz_mask) | {31'h0, msb};
                shift_carry = msb;
            end
            LSB_OP_ROTATE_RIGHT: begin
                shift_res = (opnd >> 1) |
                    (lsb_bit ? ((sz_mask >> 1) ^ sz_mask)
                             : LSB_DATA_RST);
                shift_carry = lsb_bit;
            end
            LSB_OP_ROTATE_CARRY_LEFT: begin
                shift_res = ((opnd << 1) & sz_mask)
                    | {31'h0, carry_in};
                shift_carry = msb;
            end
            LSB_OP_ROTATE_CARRY_RIGHT: begin
                shift_res = (opnd >> 1) |
                    (carry_in ? ((sz_mask >> 1) ^ sz_mask)
                              : LSB_DATA_RST);
                shift_carry = lsb_bit;
            end
            default: begin
                is_shift = 1'b0;
            end
        endcase
    end

    // =========================================================
    // bit unit hookup: byte from register half or memory
    assign bit_byte = use_mem_in ? mem_byte_in : opnd[7:0];
    assign bit_bus.byte_val = bit_byte;
    // register index form uses low three bits of the source register
    assign bit_bus.bit_idx = bit_idx_from_reg_in ? src_in[2:0]
                                                 : bit_idx_imm_in;
    assign bit_bus.op = op_in;
    assign bit_bus.carry_val = carry_in;
    assign is_bit = bit_bus.legal;
    // inverted forms accept only an immediate index
    assign imm_only = (op_in == LSB_OP_CARRY_AND_INV_BIT) ||
                      (op_in == LSB_OP_CARRY_OR_INV_BIT) ||
                      (op_in == LSB_OP_CARRY_XOR_INV_BIT) ||
                      (op_in == LSB_OP_INV_BIT_LOAD_CARRY) ||
                      (op_in == LSB_OP_INV_CARRY_STORE_BIT);

    lsb_bit_unit u_bit (
        .bus(bit_bus)
    );

    // =========================================================
    // put a right-aligned result back into its register part
    function automatic logic [31:0] merge_part(
        input logic [31:0] full,
        input logic [31:0] part,
        input lsb_size_t sz,
        input logic hi_byte,
        input logic hi_word
    );
        logic [31:0] m;
        m = full;
        case (sz)
            LSB_SZ_BYTE: begin
                if (hi_byte) begin
                    m[15:8] = part[7:0];
                end else begin
                    m[7:0] = part[7:0];
                end
            end
            LSB_SZ_WORD: begin
                if (hi_word) begin
                    m[31:16] = part[15:0];
                end else begin
                    m[15:0] = part[15:0];
                end
            end
            default: m = part;
        endcase
        return m;
    endfunction : merge_part

    // =========================================================
    // next-state: one result per request, one cycle later
    always_comb begin
        merged = dst_in;
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.reg_wr = 1'b0;
        nxt_st.mem_wr = 1'b0;
        nxt_st.carry_wr = 1'b0;
        nxt_st.zero_wr = 1'b0;
        nxt_st.illegal = 1'b0;
        if (start_in) begin
            nxt_st.done = 1'b1;
            if (is_logic) begin
                merged = merge_part(dst_in, logic_res, size_in,
                                    byte_high_in, word_upper_in);
                nxt_st.result = merged;
                nxt_st.reg_wr = 1'b1;
            end else if (is_shift) begin
                merged = merge_part(dst_in, shift_res, size_in,
                                    byte_high_in, word_upper_in);
                nxt_st.result = merged;
                nxt_st.reg_wr = 1'b1;
                nxt_st.carry = shift_carry;
                nxt_st.carry_wr = 1'b1;
            end else if (is_bit && !(imm_only && bit_idx_from_reg_in)) begin
                nxt_st.carry = bit_bus.carry_res;
                nxt_st.carry_wr = bit_bus.carry_wr;
                nxt_st.zero = bit_bus.zero_res;
                nxt_st.zero_wr = bit_bus.zero_wr;
                if (bit_bus.byte_wr && use_mem_in) begin
                    nxt_st.mem_byte = bit_bus.byte_res;
                    nxt_st.mem_wr = 1'b1;
                end else if (bit_bus.byte_wr) begin
                    // bit ops are byte-sized: pick high or low half
                    nxt_st.result = merge_part(dst_in,
                        {24'h0, bit_bus.byte_res}, LSB_SZ_BYTE,
                        byte_high_in, 1'b0);
                    nxt_st.reg_wr = 1'b1;
                end
            end else begin
                nxt_st.illegal = 1'b1; // refused, nothing written
            end
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_out = st_ff.done;
    assign result_out = st_ff.result;
    assign reg_wr_out = st_ff.reg_wr;
    assign mem_byte_out = st_ff.mem_byte;
    assign mem_wr_out = st_ff.mem_wr;
    assign carry_out = st_ff.carry;
    assign carry_wr_out = st_ff.carry_wr;
    assign zero_out = st_ff.zero;
    assign zero_wr_out = st_ff.zero_wr;
    assign illegal_out = st_ff.illegal;

    // =========================================================
    // checks
    sequence s_req(lsb_op_t o);
        start_in && op_in == o;
    endsequence

    chk_and_result: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) s_req(LSB_OP_AND) ##0 size_in == LSB_SZ_LONG
        |=> reg_wr_out && result_out == $past(dst_in & src_val))
        else $error("and result wrong");
    chk_or_result: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) s_req(LSB_OP_OR) ##0 size_in == LSB_SZ_LONG
        |=> result_out == $past(dst_in | src_val))
        else $error("or result wrong");
    chk_xor_result: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) s_req(LSB_OP_XOR) ##0 size_in == LSB_SZ_LONG
        |=> result_out == $past(dst_in ^ src_val))
        else $error("xor result wrong");
    chk_not_byte: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) s_req(LSB_OP_NOT) ##0 (size_in == LSB_SZ_BYTE
        && !byte_high_in)
        |=> result_out[7:0] == ~$past(dst_in[7:0])
        && result_out[31:8] == $past(dst_in[31:8]))
        else $error("not byte wrong");
    chk_sar_sign: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) s_req(LSB_OP_ARITH_SHIFT_RIGHT) ##0 (size_in ==
        LSB_SZ_WORD && !word_upper_in)
        |=> result_out[15] == $past(dst_in[15])
        && carry_out == $past(dst_in[0]))
        else $error("arith right sign lost");
    chk_shr_zero: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) s_req(LSB_OP_LOGIC_SHIFT_RIGHT) ##0 size_in ==
        LSB_SZ_LONG |=> !result_out[31])
        else $error("logic right fill not zero");
    chk_rotc_carry: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) s_req(LSB_OP_ROTATE_CARRY_LEFT) ##0 size_in ==
        LSB_SZ_LONG |=> result_out[0] == $past(carry_in)
        && carry_out == $past(dst_in[31]) && carry_wr_out)
        else $error("rotate carry wrong");
    chk_bit_test_op_zero: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) s_req(LSB_OP_BIT_TEST) ##0 use_mem_in
        |=> zero_wr_out && !mem_wr_out && !reg_wr_out
        && zero_out == !$past(mem_byte_in[bit_bus.bit_idx]))
        else $error("bit test zero wrong");
    chk_inv_reg_idx: assert property (@(posedge clock_in) disable iff
        (!rst_b_in) imm_only && start_in && bit_idx_from_reg_in
        |=> illegal_out && !carry_wr_out && !mem_wr_out)
        else $error("register index accepted");
endmodule : lsb_alu

// >>> bench/tb_top.sv
// self-checking bench for the logic, shift and bit alu
`timescale 1ns/1ps
// one counted compare; a mismatch is reported at once
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
$display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_top
    import lsb_pkg::*;
;
    // =========================================================
    // stimulus and observed signals; stimulus defined at time zero, outputs unknown until the first reset edge
    logic clock_in = 1'b0, rst_b_in = 1'b0, start_in = 1'b0;
    logic use_imm_in = 1'b0, bit_idx_from_reg_in = 1'b0, use_mem_in = 1'b0;
    logic byte_high_in = 1'b0, word_upper_in = 1'b0, carry_in = 1'b0;
    lsb_op_t op_in = LSB_OP_AND;
    lsb_size_t size_in = LSB_SZ_BYTE;
    logic [31:0] dst_in = '0, src_in = '0, immediate_value_in = '0;
    logic [2:0] bit_idx_imm_in = '0;
    logic [7:0] mem_byte_in = '0, mem_byte_out;
    logic [31:0] result_out;
    logic done_out, reg_wr_out, mem_wr_out, carry_out, carry_wr_out;
    logic zero_out, zero_wr_out, illegal_out;
    int failures = 0, checks_done = 0;
    localparam lsb_size_t sb = LSB_SZ_BYTE;
    localparam lsb_size_t sw = LSB_SZ_WORD;
    localparam lsb_size_t sl = LSB_SZ_LONG;

    lsb_alu dut_u (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .start_in(start_in), .op_in(op_in), .size_in(size_in),
        .dst_in(dst_in), .src_in(src_in),
        .immediate_value_in(immediate_value_in), .use_imm_in(use_imm_in),
        .bit_idx_imm_in(bit_idx_imm_in),
        .bit_idx_from_reg_in(bit_idx_from_reg_in),
        .mem_byte_in(mem_byte_in), .use_mem_in(use_mem_in),
        .byte_high_in(byte_high_in), .word_upper_in(word_upper_in),
        .carry_in(carry_in), .done_out(done_out), .result_out(result_out),
        .reg_wr_out(reg_wr_out), .mem_byte_out(mem_byte_out),
        .mem_wr_out(mem_wr_out), .carry_out(carry_out),
        .carry_wr_out(carry_wr_out), .zero_out(zero_out),
        .zero_wr_out(zero_wr_out), .illegal_out(illegal_out));

    // free-running 200 MHz clock
    initial begin
        forever #2.5 clock_in = ~clock_in;
    end

    // =========================================================
    // request helpers
    // taken at the next edge, answer registered at that same edge
    task automatic go();
        start_in <= 1'b1;
        @(posedge clock_in);
        start_in <= 1'b0;
        #1;
    endtask : go

    // register op; f = {imm, high byte, upper word, carry}
    task automatic ld(lsb_op_t op, lsb_size_t sz, logic [3:0] f,
        logic [31:0] d, logic [31:0] s, logic [31:0] er, logic ec);
        logic cw;
        cw = op >= LSB_OP_ARITH_SHIFT_LEFT && op <= LSB_OP_ROTATE_CARRY_RIGHT;
        @(posedge clock_in);
        op_in <= op;
        size_in <= sz;
        dst_in <= d;
        src_in <= f[3] ? ~s : s;
        immediate_value_in <= f[3] ? s : ~s;
        use_imm_in <= f[3];
        byte_high_in <= f[2];
        word_upper_in <= f[1];
        carry_in <= f[0];
        use_mem_in <= 1'b0;
        go();
        `CHK({done_out, reg_wr_out, mem_wr_out, illegal_out, carry_wr_out},
            {4'hC, cw})
        `CHK(result_out, er)
        if (cw) `CHK(carry_out, ec)
    endtask : ld

    // byte bit op; f = {memory, index from register, high byte, carry}
    // the unused place carries the inverse so a wrong pick shows up
    task automatic bo(lsb_op_t op, logic [3:0] f, logic [7:0] b,
        logic [2:0] i, logic [7:0] e, logic [1:0] ew);
        logic [7:0] rb;
        logic tst;
        rb = f[3] ? ~b : b;
        tst = op == LSB_OP_BIT_TEST;
        @(posedge clock_in);
        op_in <= op;
        size_in <= sb;
        use_mem_in <= f[3];
        bit_idx_from_reg_in <= f[2];
        byte_high_in <= f[1];
        carry_in <= f[0];
        mem_byte_in <= f[3] ? b : ~b;
        dst_in <= f[1] ? {16'hA5A5, rb, 8'h3C} : {16'hA5A5, 8'h3C, rb};
        src_in <= {29'h0, f[2] ? i : ~i};
        bit_idx_imm_in <= f[2] ? ~i : i;
        go();
        `CHK({done_out, illegal_out, mem_wr_out, reg_wr_out},
            {1'b1, ew == 2'h0, ew[1] & f[3], ew[1] & ~f[3]})
        `CHK({carry_wr_out, zero_wr_out}, {ew[0] & ~tst, ew[0] & tst})
        if (ew[1] & f[3]) `CHK(mem_byte_out, e)
        if (ew[1] & ~f[3]) `CHK(result_out, f[1] ? {16'hA5A5, e, 8'h3C}
            : {16'hA5A5, 8'h3C, e})
        if (ew[0]) `CHK(tst ? zero_out : carry_out, e[0])
    endtask : bo

    // =========================================================
    // scenarios
    // logic ops at each size, halves and immediate selection
    task automatic t_logic();
        ld(LSB_OP_AND, sl, 4'h0, 32'hF0F0_F0F0, 32'hFF00_FF00,
            32'hF000_F000, 1'b0);
        ld(LSB_OP_AND, sw, 4'h8, 32'h1234_5678, 32'h0000_0F0F,
            32'h1234_0608, 1'b0);
        ld(LSB_OP_OR, sb, 4'hC, 32'h1234_5678, 32'h0000_000F,
            32'h1234_5F78, 1'b0);
        ld(LSB_OP_XOR, sw, 4'h2, 32'h1234_5678, 32'h0000_FFFF,
            32'hEDCB_5678, 1'b0);
        ld(LSB_OP_NOT, sb, 4'h0, 32'h1234_5678, '0,
            32'h1234_5687, 1'b0);
    endtask : t_logic

    // single-bit shifts and rotates, leaving bit goes to carry
    task automatic t_shift();
        ld(LSB_OP_ARITH_SHIFT_RIGHT, sb, 4'h0, 32'h1234_5681, '0,
            32'h1234_56C0, 1'b1);
        ld(LSB_OP_ARITH_SHIFT_RIGHT, sl, 4'h0, 32'h8000_0002, '0,
            32'hC000_0001, 1'b0);
        ld(LSB_OP_ARITH_SHIFT_LEFT, sw, 4'h2, 32'hC001_1234, '0,
            32'h8002_1234, 1'b1);
        ld(LSB_OP_LOGIC_SHIFT_RIGHT, sw, 4'h0, 32'hFFFF_8001, '0,
            32'hFFFF_4000, 1'b1);
        ld(LSB_OP_LOGIC_SHIFT_LEFT, sb, 4'h4, 32'h0000_81FF, '0,
            32'h0000_02FF, 1'b1);
        ld(LSB_OP_ROTATE_LEFT, sb, 4'h0, 32'h0000_0081, '0,
            32'h0000_0003, 1'b1);
        ld(LSB_OP_ROTATE_RIGHT, sl, 4'h0, 32'h0000_0001, '0,
            32'h8000_0000, 1'b1);
        ld(LSB_OP_ROTATE_CARRY_LEFT, sb, 4'h0, 32'h0000_0080, '0,
            32'h0000_0000, 1'b1);
        ld(LSB_OP_ROTATE_CARRY_RIGHT, sw, 4'h3, 32'h0002_0000, '0,
            32'h8001_0000, 1'b0);
        ld(LSB_OP_ROTATE_CARRY_LEFT, sl, 4'h1, 32'h4000_0000, '0,
            32'h8000_0001, 1'b0);
    endtask : t_shift

    // byte writers; inverted store with register index must be refused
    task automatic t_bit_write();
        lsb_op_t wop [5];
        int n;
        logic [7:0] b, m, e;
        logic [2:0] i;
        wop = '{LSB_OP_BIT_SET, LSB_OP_BIT_CLEAR, LSB_OP_BIT_INVERT,
            LSB_OP_CARRY_STORE_BIT, LSB_OP_INV_CARRY_STORE_BIT};
        for (int k = 0; k < 30; k++) begin
            n = k % 5;
            i = 3'(k * 3);
            m = 8'h01 << i;
            b = {k[3:0], ~k[3:0]};
            case (n)
                0: e = b | m;
                1: e = b & ~m;
                2: e = b ^ m;
                3: e = k[3] ? b | m : b & ~m;
                default: e = k[3] ? b & ~m : b | m;
            endcase
            bo(wop[n], {k[0], k[1], k[2], k[3]}, b, i, e,
                (n == 4 && k[1]) ? 2'h0 : 2'h2);
        end
    endtask : t_bit_write

    // every carry bit op against four of the eight places, each index form and half
    task automatic t_bit_carry();
        logic [2:0] n, i;
        logic c, x, e;
        for (int k = 0; k < 256; k++) begin
            n = k[4:2];
            c = k[0];
            i = 3'(k * 5);
            x = k[1] ^ n[0];
            case (n[2:1])
                2'h0: e = c & x;
                2'h1: e = c | x;
                2'h2: e = c ^ x;
                default: e = x;
            endcase
            bo(lsb_op_t'(5'(LSB_OP_CARRY_AND_BIT + n)),
                {k[5], k[6], k[7], c}, k[1] ? 8'h01 << i : ~(8'h01 << i),
                i, {7'h0, e},
                (n[0] && k[6]) ? 2'h0 : 2'h1);
        end
        bo(lsb_op_t'(5'h1F), 4'h0, 8'h00, 3'h0, 8'h00, 2'h0);
        bo(LSB_OP_BIT_TEST, 4'h8, 8'hF7, 3'h3, 8'h01, 2'h1);
        bo(LSB_OP_BIT_TEST, 4'h6, 8'h08, 3'h3, 8'h00, 2'h1);
    endtask : t_bit_carry

    // verdict and end of run
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // reset, then every scenario in turn
    initial begin
        repeat (4) @(posedge clock_in);
        rst_b_in <= 1'b1;
        #1;
        `CHK({done_out, reg_wr_out, result_out, carry_out}, 35'h0)
        t_logic();
        t_shift();
        t_bit_write();
        t_bit_carry();
        tally_and_finish();
    end

    // about 610 cycles are needed; a hang ends far later as a failure
    initial begin
        #20000;
        failures++;
        tally_and_finish();
    end
endmodule : tb_top
